// ### hw/ahp_pkg.sv
`default_nettype none
package ahp_pkg;
    // Serial frame: one command byte, then one data word
    localparam int CMD_W = 8;
    localparam int DATA_W = 16;
    localparam int CNT_W = 5;
    localparam int CMD_RD_BIT = 7;
    localparam int CMD_IDX_LSB = 0;
    localparam int CMD_IDX_W = 2;
    // Register indices carried in the command byte
    localparam logic [1:0] IDX_CTRL = 2'h0;
    localparam logic [1:0] IDX_STATUS = 2'h1;
    localparam logic [1:0] IDX_RESULT = 2'h2;
    // Field positions
    localparam int CTRL_EXT_CLK_POS = 0;
    localparam int STAT_LOW_BATT_POS = 0;
    localparam int STAT_READY_POS = 1;
    // Reset values
    localparam logic CTRL_EXT_CLK_RST = 1'b0;
    // Timing
    localparam longint CLK_HZ = 125000000;
    localparam longint INT_OSC_HZ = 4915200;
    localparam int INT_DIV = int'(CLK_HZ / INT_OSC_HZ);
    localparam logic [4:0] INT_DIV_LAST = 5'(INT_DIV - 1);

    typedef enum logic [1:0] {
        ST_CMD = 2'b00,
        ST_WDATA = 2'b01,
        ST_RDATA = 2'b10,
        ST_DONE = 2'b11
    } ahp_state_t;
endpackage : ahp_pkg
`default_nettype wire

// ### hw/ahp_serial_port.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R01 - Control bit set: external clock pin paces modulator and filter.
// R02 - Control bit clear: internal oscillator paces them; external pin ignored.
// R03 - External-clock select reads zero after reset.
// R04 - Low battery input sets the display indicator and a latched status flag.
// R05 - Low battery flag stays set until software reads or clears status.
// R06 - Conversion-done output low while a new unread result waits.
// R07 - Serial port responds only while chip select is low.
// R08 - Input bit captured on each serial clock rising edge with select low during the command and write-data phases.
// R09 - Host supplies the serial clock and may idle it either level.
// R10 - Port works whether the serial clock idles high or low.
// R11 - Serial output driven only for a register read query.
// R12 - Serial output moves to the next bit on each falling edge.
// R13 - Serial output released whenever chip select is high.
module ahp_serial_port
    import ahp_pkg::*;
#(
    parameter int DW = DATA_W
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic DIN,
    output logic DOUT,
    output logic DOUT_OE,
    input wire logic EXT_CLK,
    output logic MOD_TICK,
    input wire logic BATT_LOW,
    output logic LOW_BATT_SEG,
    input wire logic [DW-1:0] RESULT,
    input wire logic RESULT_VALID,
    output logic EOC_N
);

    // Shifters need two bits at least; the check caps the word at sixteen bits, below what the five-bit counter serves
    if (DW < 2 || DW > 16) begin : g_dw_check
        $error("DW must be 2 to 16");
    end

    logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic cs_s1_q, cs_s2_q;
    logic din_s1_q, din_s2_q;
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic batt_s1_q, batt_s2_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            din_s1_q <= 1'b0;
            din_s2_q <= 1'b0;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            batt_s1_q <= 1'b0;
            batt_s2_q <= 1'b0;
        end else begin
            sclk_s1_q <= SCLK;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            cs_s1_q <= CS_N;
            cs_s2_q <= cs_s1_q;
            din_s1_q <= DIN;
            din_s2_q <= din_s1_q;
            ext_s1_q <= EXT_CLK;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            batt_s1_q <= BATT_LOW;
            batt_s2_q <= batt_s1_q;
        end
    end

    logic sel_n;
    logic sclk_rise, sclk_fall, ext_rise;
    assign sel_n = cs_s2_q;
    // Edges are found on the sampled level, so idle polarity does not matter
    assign sclk_rise = !sel_n && sclk_s2_q && !sclk_s3_q; // see R08, R10
    assign sclk_fall = !sel_n && !sclk_s2_q && sclk_s3_q; // see R10
    assign ext_rise = ext_s2_q && !ext_s3_q;

    ahp_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CMD_W-1:0] cmd_q;
    logic [DW-1:0] shin_q, shout_q;
    logic [CMD_W-1:0] cmd_next;
    logic [CMD_IDX_W-1:0] idx_next;
    logic cmd_done, wr_done, stat_rd, res_rd, stat_wr;

    logic ext_sel_q;
    logic low_batt_flag_q;
    logic ready_q;
    logic [DW-1:0] result_q;
    logic [DW-1:0] rd_word;
    logic [DW-1:0] wr_word;

    assign cmd_next = {cmd_q[CMD_W-2:0], din_s2_q};
    assign idx_next = cmd_next[CMD_IDX_LSB +: CMD_IDX_W];
    assign cmd_done = state_q == ST_CMD && sclk_rise && cnt_q == CNT_W'(CMD_W - 1);
    assign wr_done = state_q == ST_WDATA && sclk_rise && cnt_q == CNT_W'(DW - 1);
    assign stat_rd = cmd_done && cmd_next[CMD_RD_BIT] && idx_next == IDX_STATUS;
    assign res_rd = cmd_done && cmd_next[CMD_RD_BIT] && idx_next == IDX_RESULT;
    assign stat_wr = wr_done && cmd_q[CMD_IDX_LSB +: CMD_IDX_W] == IDX_STATUS;
    // Data word as it stands once its last bit is in
    assign wr_word = {shin_q[DW-2:0], din_s2_q};

    always_comb begin
        rd_word = '0;
        case (idx_next)
            IDX_CTRL: rd_word[CTRL_EXT_CLK_POS] = ext_sel_q;
            IDX_STATUS: begin
                rd_word[STAT_LOW_BATT_POS] = low_batt_flag_q;
                rd_word[STAT_READY_POS] = ready_q;
            end
            IDX_RESULT: rd_word = result_q;
            default: rd_word = '0;
        endcase
    end

    // Frame sequencer; chip select high returns it to the command phase
    always_ff @(posedge CLK) begin
        if (SRST || sel_n) begin // see R07
            state_q <= ST_CMD;
            cnt_q <= '0;
            cmd_q <= '0;
            shin_q <= '0;
        end else if (sclk_rise) begin // see R08
            case (state_q)
                ST_CMD: begin
                    cmd_q <= cmd_next;
                    if (cmd_done) begin
                        cnt_q <= '0;
                        state_q <= cmd_next[CMD_RD_BIT] ? ST_RDATA : ST_WDATA;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_WDATA: begin
                    shin_q <= {shin_q[DW-2:0], din_s2_q};
                    cnt_q <= cnt_q + 1'b1;
                    if (wr_done) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_RDATA: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(DW - 1)) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: state_q <= ST_DONE;
                default: state_q <= ST_CMD;
            endcase
        end
    end

    // Output shifter: word loaded when the command ends, bits move on falling edges
    always_ff @(posedge CLK) begin
        if (SRST || sel_n) begin
            shout_q <= '0;
            DOUT <= 1'b0;
        end else if (cmd_done) begin
            shout_q <= rd_word;
        end else if (sclk_fall && state_q == ST_RDATA) begin // see R12
            DOUT <= shout_q[DW-1];
            shout_q <= {shout_q[DW-2:0], 1'b0};
        end
    end

    // Released while deselected and outside a read
    assign DOUT_OE = !sel_n && state_q == ST_RDATA; // see R11, R13

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ext_sel_q <= CTRL_EXT_CLK_RST; // see R03
        end else if (wr_done && cmd_q[CMD_IDX_LSB +: CMD_IDX_W] == IDX_CTRL) begin
            ext_sel_q <= wr_word[CTRL_EXT_CLK_POS];
        end
    end

    // Modulator and filter pace; the unselected source is ignored
    logic [4:0] div_q;
    logic int_tick;
    assign int_tick = div_q == INT_DIV_LAST;

    always_ff @(posedge CLK) begin
        if (SRST || int_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            MOD_TICK <= 1'b0;
        end else begin
            MOD_TICK <= ext_sel_q ? ext_rise : int_tick; // see R01, R02
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            low_batt_flag_q <= 1'b0;
        end else begin
            low_batt_flag_q <= batt_s2_q || (low_batt_flag_q && !stat_rd && // see R04
                !(stat_wr && wr_word[STAT_LOW_BATT_POS])); // see R05
        end
    end
    assign LOW_BATT_SEG = low_batt_flag_q; // see R04

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ready_q <= 1'b0;
            result_q <= '0;
        end else if (RESULT_VALID) begin
            ready_q <= 1'b1;
            result_q <= RESULT;
        end else if (res_rd) begin
            ready_q <= 1'b0;
        end
    end
    assign EOC_N = !ready_q; // see R06

    // Link checks
    a_dout_released: assert property (@(posedge CLK) disable iff (SRST) // see R13
        $past(CS_N, 2) |-> !DOUT_OE)
        else $error("serial output driven while deselected");
    a_dout_read_only: assert property (@(posedge CLK) disable iff (SRST) // see R11
        DOUT_OE |-> cmd_q[CMD_RD_BIT] && cnt_q < CNT_W'(DW))
        else $error("serial output driven outside a read");
    a_oe_on_read: assert property (@(posedge CLK) disable iff (SRST) // see R11
        (cmd_done && cmd_next[CMD_RD_BIT]) |=> DOUT_OE || sel_n)
        else $error("read query not answered");
    a_dout_on_fall: assert property (@(posedge CLK) disable iff (SRST) // see R12
        (!sel_n && $changed(DOUT)) |-> $past(sclk_fall))
        else $error("output moved off a falling edge");
    a_shift_on_fall: assert property (@(posedge CLK) disable iff (SRST) // see R12
        (state_q == ST_RDATA && sclk_fall) |=> shout_q == {$past(shout_q[DW-2:0]), 1'b0})
        else $error("output word not shifted");
    a_capture_edge: assert property (@(posedge CLK) disable iff (SRST) // see R08
        (state_q == ST_CMD && sclk_rise && !cmd_done) |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("input bit not counted");
    a_wdata_count: assert property (@(posedge CLK) disable iff (SRST) // see R08
        (state_q == ST_WDATA && sclk_rise) |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("data bit not counted");
    a_deselect_idle: assert property (@(posedge CLK) disable iff (SRST) // see R07
        sel_n |=> state_q == ST_CMD && cnt_q == '0)
        else $error("frame kept while deselected");

    // Pace checks
    a_ext_sel_reset: assert property (@(posedge CLK) // see R03
        (!SRST && $past(SRST)) |-> !ext_sel_q)
        else $error("external select not zero after reset");
    a_ctrl_write: assert property (@(posedge CLK) disable iff (SRST) // see R01
        (wr_done && cmd_q[CMD_IDX_LSB +: CMD_IDX_W] == IDX_CTRL)
        |=> ext_sel_q == $past(wr_word[CTRL_EXT_CLK_POS]))
        else $error("clock select not written");
    a_ext_tick_used: assert property (@(posedge CLK) disable iff (SRST) // see R01
        (ext_sel_q && ext_rise) |=> MOD_TICK)
        else $error("external edge not passed on");
    a_ext_only: assert property (@(posedge CLK) disable iff (SRST) // see R01
        (ext_sel_q && !ext_rise) |=> !MOD_TICK)
        else $error("pace tick without external edge");
    a_int_tick_only: assert property (@(posedge CLK) disable iff (SRST) // see R02
        (!ext_sel_q && !int_tick) |=> !MOD_TICK)
        else $error("pace tick without internal tick");
    a_int_tick_used: assert property (@(posedge CLK) disable iff (SRST) // see R02
        (!ext_sel_q && int_tick) |=> MOD_TICK)
        else $error("internal tick not passed on");

    // Status and result checks
    a_low_batt_set: assert property (@(posedge CLK) disable iff (SRST) // see R04
        batt_s2_q |=> low_batt_flag_q && LOW_BATT_SEG)
        else $error("low battery not latched");
    a_low_batt_hold: assert property (@(posedge CLK) disable iff (SRST) // see R05
        (low_batt_flag_q && !stat_rd && !stat_wr) |=> low_batt_flag_q)
        else $error("low battery flag lost");
    a_low_batt_clear: assert property (@(posedge CLK) disable iff (SRST) // see R05
        (stat_rd && !batt_s2_q) |=> !low_batt_flag_q)
        else $error("low battery flag kept after read");
    a_low_batt_wclr: assert property (@(posedge CLK) disable iff (SRST) // see R05
        (stat_wr && wr_word[STAT_LOW_BATT_POS] && !batt_s2_q) |=> !low_batt_flag_q)
        else $error("low battery flag kept after write");
    a_eoc_ready: assert property (@(posedge CLK) disable iff (SRST) // see R06
        RESULT_VALID |=> !EOC_N)
        else $error("result ready not shown");
    a_eoc_hold: assert property (@(posedge CLK) disable iff (SRST) // see R06
        (!EOC_N && !res_rd) |=> !EOC_N)
        else $error("result ready lost before read");
    a_eoc_clear: assert property (@(posedge CLK) disable iff (SRST) // see R06
        (res_rd && !RESULT_VALID) |=> EOC_N)
        else $error("result ready kept after read");

    c_read_frame: cover property (@(posedge CLK) disable iff (SRST)
        state_q == ST_RDATA && sclk_fall);
    c_write_ctrl: cover property (@(posedge CLK) disable iff (SRST)
        wr_done && cmd_q[CMD_IDX_LSB +: CMD_IDX_W] == IDX_CTRL);
    c_ext_mode: cover property (@(posedge CLK) disable iff (SRST) ext_sel_q && MOD_TICK);
    c_low_batt_read: cover property (@(posedge CLK) disable iff (SRST) stat_rd && low_batt_flag_q);
    c_status_clear: cover property (@(posedge CLK) disable iff (SRST) stat_wr && low_batt_flag_q);

endmodule : ahp_serial_port

`default_nettype wire

// ### testbench/ahp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ahp_host_model #(
    parameter int HALF = 10
) (
    input wire logic clk,
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    int bad = 0;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    task automatic wt();
        repeat (HALF) @(posedge clk);
    endtask : wt
    // One frame: command byte then the data word, MSB first
    task automatic xfer(input logic idle, input logic [23:0] bits, output logic [15:0] rd);
        @(posedge clk);
        // Idle level settles while deselected, so no false edge opens the frame
        sclk <= idle;
        wt();
        cs_n <= 1'b0;
        wt();
        for (int i = 23; i >= 0; i--) begin
            sclk <= 1'b0;
            din <= bits[i];
            wt();
            sclk <= 1'b1;
            if (i < 16) rd = {rd[14:0], dout};
            if (dout_oe !== (bits[23] && i < 16)) bad++;
            wt();
        end
        sclk <= idle;
        wt();
        cs_n <= 1'b1;
        din <= ~din;
        wt();
        if (dout_oe !== 1'b0) bad++;
    endtask : xfer
endmodule : ahp_host_model
`default_nettype wire

// ### testbench/tb_adc_serial_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_serial_host_port;
    import ahp_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ext_clk = 1'b0;
    logic batt_low = 1'b0;
    logic [15:0] result = 16'h0;
    logic result_valid = 1'b0;
    logic [15:0] rd;
    wire logic sclk, cs_n, din, dout, dout_oe, mod_tick, low_batt_seg, eoc_n;
    // Pin level as the host sees it: floats when released
    wire logic dout_pin = dout_oe ? dout : 1'bz;
    int errors = 0;
    int checks_done = 0;
    int ticks = 0;
    int t0;
    always #4 clk = ~clk;
    always @(posedge clk) if (mod_tick === 1'b1) ticks <= ticks + 1;
    ahp_serial_port dut_u (.CLK(clk), .SRST(srst), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
        .DOUT(dout), .DOUT_OE(dout_oe), .EXT_CLK(ext_clk), .MOD_TICK(mod_tick),
        .BATT_LOW(batt_low), .LOW_BATT_SEG(low_batt_seg), .RESULT(result),
        .RESULT_VALID(result_valid), .EOC_N(eoc_n));
    ahp_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_pin),
        .dout_oe(dout_oe));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic idle, input logic rdc, input logic [1:0] idx,
                       input logic [15:0] wd);
        host.xfer(idle, {rdc, 5'h0, idx, wd}, rd);
    endtask : acc
    task automatic ext(input int n, input int half);
        repeat (n) begin
            ext_clk <= 1'b1;
            repeat (half) @(posedge clk);
            ext_clk <= 1'b0;
            repeat (half) @(posedge clk);
        end
    endtask : ext
    task automatic t_reset();
        chk(eoc_n, 1'b1);
        chk(low_batt_seg, 1'b0);
        chk(dout_oe, 1'b0);
        acc(1'b0, 1'b1, IDX_CTRL, 16'h0);
        chk(rd, 16'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_clock();
        acc(1'b1, 1'b0, IDX_CTRL, 16'h1);
        acc(1'b0, 1'b1, IDX_CTRL, 16'h0);
        chk(rd, 16'h1);
        t0 = ticks;
        ext(10, 10);
        chk(16'(ticks - t0), 16'd10);
        acc(1'b1, 1'b0, IDX_CTRL, 16'h0);
        t0 = ticks;
        ext(25, 10);
        chk(16'(ticks - t0), 16'(500 / INT_DIV));
        $display("test clock done");
    endtask : t_clock
    task automatic t_batt();
        batt_low <= 1'b1;
        repeat (4) @(posedge clk);
        batt_low <= 1'b0;
        repeat (8) @(posedge clk);
        chk(low_batt_seg, 1'b1);
        acc(1'b0, 1'b1, IDX_STATUS, 16'h0);
        chk(rd[STAT_LOW_BATT_POS], 1'b1);
        chk(low_batt_seg, 1'b0);
        batt_low <= 1'b1;
        repeat (4) @(posedge clk);
        batt_low <= 1'b0;
        repeat (8) @(posedge clk);
        chk(low_batt_seg, 1'b1);
        acc(1'b1, 1'b0, IDX_STATUS, 16'h1);
        chk(low_batt_seg, 1'b0);
        $display("test battery done");
    endtask : t_batt
    task automatic t_result();
        result <= 16'ha5c3;
        result_valid <= 1'b1;
        @(posedge clk);
        result_valid <= 1'b0;
        repeat (4) @(posedge clk);
        chk(eoc_n, 1'b0);
        acc(1'b1, 1'b1, IDX_RESULT, 16'h0);
        chk(rd, 16'ha5c3);
        chk(eoc_n, 1'b1);
        chk(16'(host.bad), 16'h0);
        $display("test result done");
    endtask : t_result
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_clock();
        t_batt();
        t_result();
        conclude();
    end
endmodule : tb_adc_serial_host_port
`default_nettype wire
